// ===== rtl/scmh_pkg.sv
/*
  Shared constants and types for the scan master host port: host address
  map, buffer region layout, field positions and carrier structs.
  Assumes a single system clock domain and a 2048 x 32 shared buffer.
*/
package scmh_pkg;

  // Buffer geometry
  localparam int MEM_DEPTH = 2048;
  localparam int MEM_AW    = 11;
  localparam int MEM_W     = 32;
  localparam int HALF_W    = 16;
  localparam int HADR_W    = 5;
  localparam int NUM_RG    = 9;

  // Strobe synchroniser depth for each host kind
  localparam int ASYNC_STAGES = 2;
  localparam int SYNC_STAGES  = 1;

  typedef logic [HADR_W-1:0] scmh_hadr_t;
  typedef logic [3:0]        scmh_rg_t;
  typedef logic [MEM_AW-1:0] scmh_maddr_t;

  // Host register and window addresses
  localparam scmh_hadr_t ADR_START   = 5'h00;
  localparam scmh_hadr_t ADR_SETUP   = 5'h01;
  localparam scmh_hadr_t ADR_INTMASK = 5'h02;
  localparam scmh_hadr_t ADR_INTSTAT = 5'h03;
  localparam scmh_hadr_t ADR_STATUS  = 5'h04;
  localparam scmh_hadr_t ADR_INDEX   = 5'h05;
  localparam scmh_hadr_t ADR_SEED    = 5'h06;
  localparam scmh_hadr_t ADR_RESULT  = 5'h07;
  localparam scmh_hadr_t ADR_REGION0 = 5'h08;
  localparam scmh_hadr_t ADR_PTR4    = 5'h11;

  // Region numbers
  localparam scmh_rg_t RG_OUT  = 4'h0;
  localparam scmh_rg_t RG_IN   = 4'h1;
  localparam scmh_rg_t RG_EXP  = 4'h2;
  localparam scmh_rg_t RG_MASK = 4'h3;
  localparam scmh_rg_t RG_VEC  = 4'h4;
  localparam scmh_rg_t RG_NONE = 4'hF;

  // Setup register field and reset values
  localparam int SETUP_TRST2_BIT = 1;
  localparam logic [HALF_W-1:0] REG_RESET = 16'h0000;

  // Fixed base address of each region
  function automatic scmh_maddr_t scmh_base(input scmh_rg_t rg);
    case (rg)
      4'h0:    scmh_base = 11'h000;
      4'h1:    scmh_base = 11'h100;
      4'h2:    scmh_base = 11'h200;
      4'h3:    scmh_base = 11'h300;
      4'h4:    scmh_base = 11'h400;
      4'h5:    scmh_base = 11'h500;
      4'h6:    scmh_base = 11'h600;
      4'h7:    scmh_base = 11'h700;
      default: scmh_base = 11'h780;
    endcase
  endfunction

  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_ACK} scmh_state_t;

  // Scan engine access to its own port of the buffer
  typedef struct packed {
    logic              we;
    scmh_maddr_t       addr;
    logic [MEM_W-1:0]  wdata;
  } scmh_se_req_t;

endpackage

// ===== rtl/scmh_host_port.sv
/*
  Host parallel port and shared vector buffer of a boundary scan master.
  Holds the strobe edge detector, access controller, region pointers,
  word/long word conversion, control, status and interrupt registers.
  Assumes host address and data are stable while the strobe is low and
  that the serial scan engine sits on the second buffer port.
*/
`timescale 1ns/1ps

module scmh_host_port #(
  parameter int DATA_W     = 16,
  parameter bit ASYNC_HOST = 1'b1,
  parameter int NUM_EVT    = 8
) (
  input  wire logic                    MCLK_I,
  input  wire logic                    RESET_N_I,
  input  wire logic                    CE_N_I,
  input  wire logic                    STB_N_I,
  input  wire logic                    RW_I,
  input  wire scmh_pkg::scmh_hadr_t    ADDR_I,
  input  wire logic [DATA_W-1:0]       DATA_I,
  output logic      [DATA_W-1:0]       DATA_O,
  output logic                         DATA_OE_O,
  output logic                         ACK_N_O,
  input  wire scmh_pkg::scmh_se_req_t  SE_REQ_I,
  output logic      [31:0]             SE_RDATA_O,
  input  wire logic [NUM_EVT-1:0]      SE_EVT_I,
  input  wire logic [15:0]             SE_STATUS_I,
  input  wire logic [31:0]             SE_RESULT_I,
  input  wire logic                    SE_RESULT_STB_I,
  output logic                         SE_CTL_STB_O,
  output logic      [15:0]             SE_START_O,
  output logic      [15:0]             SE_SETUP_O,
  output logic      [31:0]             SE_SEED_O,
  output logic                         INT_O,
  output logic                         TRST_SECOND_O
);

  localparam int SYNC_N = ASYNC_HOST ? scmh_pkg::ASYNC_STAGES : scmh_pkg::SYNC_STAGES;
  localparam bit WIDE   = (DATA_W == 32);

  // Region lookup, used for data windows and pointer registers
  function automatic scmh_pkg::scmh_rg_t data_rg(input scmh_pkg::scmh_hadr_t a);
    if (a >= scmh_pkg::ADR_REGION0 && a < scmh_pkg::ADR_REGION0 + 5'h09) begin
      data_rg = 4'(a - scmh_pkg::ADR_REGION0);
    end else begin
      data_rg = scmh_pkg::RG_NONE;
    end
  endfunction

  function automatic scmh_pkg::scmh_rg_t ptr_rg(input scmh_pkg::scmh_hadr_t a);
    if (a >= scmh_pkg::ADR_PTR4 && a < scmh_pkg::ADR_PTR4 + 5'h05) begin
      ptr_rg = 4'(a - scmh_pkg::ADR_PTR4) + scmh_pkg::RG_VEC;
    end else begin
      ptr_rg = scmh_pkg::RG_NONE;
    end
  endfunction

  // Strobe and select synchroniser state
  logic [SYNC_N-1:0] stb_sh_q, stb_sh_d, ce_sh_q, ce_sh_d;
  logic              stb_prev_q, ce_prev_q;
  logic              stb_fall, stb_rise, ce_fall, acc_go;

  // Two stages for an async host, one for a sync host; the first stage
  // feeds only the second, so edges are taken from the settled end
  always_comb begin
    stb_sh_d[0] = STB_N_I;
    ce_sh_d[0]  = CE_N_I;
    for (int i = 1; i < SYNC_N; i++) begin
      stb_sh_d[i] = stb_sh_q[i-1];
      ce_sh_d[i]  = ce_sh_q[i-1];
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stb_sh_q   <= '1;
      ce_sh_q    <= '1;
      stb_prev_q <= 1'b1;
      ce_prev_q  <= 1'b1;
    end else begin
      stb_sh_q   <= stb_sh_d;
      ce_sh_q    <= ce_sh_d;
      stb_prev_q <= stb_sh_q[SYNC_N-1];
      ce_prev_q  <= ce_sh_q[SYNC_N-1];
    end
  end

  // One-cycle edge pulses; sampling jitter moves them by one clock
  assign stb_fall = stb_prev_q & ~stb_sh_q[SYNC_N-1];
  assign stb_rise = ~stb_prev_q & stb_sh_q[SYNC_N-1];
  assign ce_fall  = ce_prev_q & ~ce_sh_q[SYNC_N-1];
  assign acc_go   = (stb_fall & ~ce_sh_q[SYNC_N-1]) | (ce_fall & ~stb_sh_q[SYNC_N-1]);

  // Access controller and register state
  scmh_pkg::scmh_state_t  st_q, st_d;
  scmh_pkg::scmh_maddr_t  ptr_q [scmh_pkg::NUM_RG];
  scmh_pkg::scmh_maddr_t  ptr_d [scmh_pkg::NUM_RG];
  logic [DATA_W-1:0]      dout_q, dout_d;
  logic                   oe_q, oe_d, ack_n_q, ack_n_d;
  logic                   half_q, half_d, pair_q, pair_d;
  logic [15:0]            hold_wr_q, hold_wr_d, hold_rd_q, hold_rd_d;
  logic [15:0]            start_q, start_d, setup_q, setup_d, mask_q, mask_d;
  logic [31:0]            seed_q, seed_d, result_q, result_d;
  logic [NUM_EVT-1:0]     int_q, int_d;
  logic                   ctl_stb_q, ctl_stb_d, int_o_q, int_o_d;
  logic [31:0]            din, mem_rd_q, mem_wdata, rd_val;
  scmh_pkg::scmh_maddr_t  mem_addr, cur_ptr;
  scmh_pkg::scmh_rg_t     rg, prg;
  logic                   mem_we, long_done, int_rd;

  // Address and data for the live host access
  always_comb begin
    din                 = '0;
    din[DATA_W-1:0]     = DATA_I;
    rg                  = data_rg(ADDR_I);
    prg                 = ptr_rg(ADDR_I);
    cur_ptr             = (rg == scmh_pkg::RG_NONE) ? '0 : ptr_q[rg];
    mem_addr            = scmh_pkg::scmh_base(rg) + cur_ptr;
    long_done           = WIDE | half_q;
    // Big-endian: in 16-bit mode the first write carries the MS word
    mem_wdata           = WIDE ? din : {hold_wr_q, din[15:0]};
    if (rg == scmh_pkg::RG_VEC) begin
      mem_wdata[31:16]  = 16'h0000;
    end
    mem_we              = (st_q == scmh_pkg::ST_IDLE) && acc_go && !RW_I &&
                          rg != scmh_pkg::RG_NONE && long_done;
    int_rd              = (st_q == scmh_pkg::ST_IDLE) && acc_go && RW_I &&
                          ADDR_I == scmh_pkg::ADR_INTSTAT;
    rd_val              = WIDE ? mem_rd_q : {16'h0000, mem_rd_q[31:16]};
    if (rg == scmh_pkg::RG_VEC) begin
      rd_val[31:16]     = 16'h0000;
    end
  end

  // Next state of the controller, pointers and registers
  always_comb begin
    st_d      = st_q;
    ptr_d     = ptr_q;
    dout_d    = dout_q;
    oe_d      = oe_q;
    ack_n_d   = ack_n_q;
    half_d    = half_q;
    pair_d    = pair_q;
    hold_wr_d = hold_wr_q;
    hold_rd_d = hold_rd_q;
    start_d   = start_q;
    setup_d   = setup_q;
    mask_d    = mask_q;
    seed_d    = seed_q;
    result_d  = SE_RESULT_STB_I ? SE_RESULT_I : result_q;
    ctl_stb_d = 1'b0;
    // Event set wins over the read clear, so nothing is lost
    int_d     = (int_rd ? '0 : int_q) | SE_EVT_I;
    int_o_d   = |(int_q & mask_q[NUM_EVT-1:0]);
    case (st_q)
      scmh_pkg::ST_IDLE: begin
        if (acc_go) begin
          st_d    = scmh_pkg::ST_ACK;
          ack_n_d = 1'b0;
          oe_d    = RW_I;
          if (rg != scmh_pkg::RG_NONE) begin
            if (RW_I && !long_done) begin
              st_d    = scmh_pkg::ST_MEM;   // Fetch needs one more clock
              ack_n_d = 1'b1;
              oe_d    = 1'b0;
            end else if (RW_I) begin
              dout_d    = DATA_W'({16'h0000, hold_rd_q});
              half_d    = 1'b0;
              ptr_d[rg] = ptr_q[rg] + 11'h001;
            end else if (long_done) begin
              half_d    = 1'b0;
              ptr_d[rg] = ptr_q[rg] + 11'h001;
            end else begin
              hold_wr_d = din[15:0];
              half_d    = 1'b1;
            end
            if (RW_I && WIDE) begin
              st_d    = scmh_pkg::ST_MEM;
              ack_n_d = 1'b1;
              oe_d    = 1'b0;
            end
          end else if (prg != scmh_pkg::RG_NONE) begin
            if (RW_I) begin
              dout_d     = DATA_W'({5'h00, ptr_q[prg]});
            end else begin
              ptr_d[prg] = din[10:0];
            end
          end else begin
            // Registers use the LS word only, in either width
            dout_d = '0;
            case (ADDR_I)
              scmh_pkg::ADR_START: begin
                if (RW_I) dout_d = DATA_W'(start_q);
                else begin
                  start_d   = din[15:0];
                  ctl_stb_d = 1'b1;
                end
              end
              scmh_pkg::ADR_SETUP: begin
                if (RW_I) dout_d = DATA_W'(setup_q);
                else begin
                  setup_d   = din[15:0];
                  ctl_stb_d = 1'b1;
                end
              end
              scmh_pkg::ADR_INTMASK: begin
                if (RW_I) dout_d = DATA_W'(mask_q);
                else mask_d = din[15:0];
              end
              scmh_pkg::ADR_INTSTAT: begin
                if (RW_I) dout_d = DATA_W'({{(16-NUM_EVT){1'b0}}, int_q});
              end
              scmh_pkg::ADR_STATUS: begin
                if (RW_I) dout_d = DATA_W'(SE_STATUS_I);
              end
              scmh_pkg::ADR_INDEX: begin
                if (!RW_I) begin
                  for (int r = 0; r <= 3; r++) begin
                    ptr_d[r] = din[10:0];
                  end
                end
              end
              scmh_pkg::ADR_SEED: begin
                pair_d = ~pair_q;
                if (RW_I) dout_d = DATA_W'(pair_q ? seed_q[31:16] : seed_q[15:0]);
                else if (pair_q) seed_d[31:16] = din[15:0];
                else seed_d[15:0] = din[15:0];
              end
              scmh_pkg::ADR_RESULT: begin
                pair_d = ~pair_q;
                if (RW_I) dout_d = DATA_W'(pair_q ? result_q[31:16] : result_q[15:0]);
              end
              default: dout_d = '0;   // Unmapped reads as zero
            endcase
          end
        end
      end
      scmh_pkg::ST_MEM: begin
        st_d      = scmh_pkg::ST_ACK;
        ack_n_d   = 1'b0;
        oe_d      = 1'b1;
        dout_d    = DATA_W'(rd_val);
        hold_rd_d = mem_rd_q[15:0];
        if (WIDE) begin
          ptr_d[data_rg(ADDR_I)] = cur_ptr + 11'h001;
        end else begin
          half_d = 1'b1;
        end
      end
      scmh_pkg::ST_ACK: begin
        if (stb_rise || ce_sh_q[SYNC_N-1]) begin
          st_d    = scmh_pkg::ST_IDLE;
          ack_n_d = 1'b1;
          oe_d    = 1'b0;
        end
      end
      default: st_d = scmh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q      <= scmh_pkg::ST_IDLE;
      ptr_q     <= '{default: '0};
      dout_q    <= '0;
      oe_q      <= 1'b0;
      ack_n_q   <= 1'b1;
      half_q    <= 1'b0;
      pair_q    <= 1'b0;
      hold_wr_q <= '0;
      hold_rd_q <= '0;
      start_q   <= scmh_pkg::REG_RESET;
      setup_q   <= scmh_pkg::REG_RESET;
      mask_q    <= scmh_pkg::REG_RESET;
      seed_q    <= '0;
      result_q  <= '0;
      int_q     <= '0;
      ctl_stb_q <= 1'b0;
      int_o_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      ptr_q     <= ptr_d;
      dout_q    <= dout_d;
      oe_q      <= oe_d;
      ack_n_q   <= ack_n_d;
      half_q    <= half_d;
      pair_q    <= pair_d;
      hold_wr_q <= hold_wr_d;
      hold_rd_q <= hold_rd_d;
      start_q   <= start_d;
      setup_q   <= setup_d;
      mask_q    <= mask_d;
      seed_q    <= seed_d;
      result_q  <= result_d;
      int_q     <= int_d;
      ctl_stb_q <= ctl_stb_d;
      int_o_q   <= int_o_d;
    end
  end

  // Shared buffer; no arbitration, so a same-address clash is the
  // software's problem, in the capture region above all
  logic [31:0] mem [scmh_pkg::MEM_DEPTH];
  logic [31:0] se_rd_q;

  always_ff @(posedge MCLK_I) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    mem_rd_q <= mem[mem_addr];
    if (SE_REQ_I.we) mem[SE_REQ_I.addr] <= SE_REQ_I.wdata;
    se_rd_q <= mem[SE_REQ_I.addr];
  end

  // Outputs straight from flip-flops
  assign DATA_O        = dout_q;
  assign DATA_OE_O     = oe_q;
  assign ACK_N_O       = ack_n_q;
  assign SE_RDATA_O    = se_rd_q;
  assign SE_CTL_STB_O  = ctl_stb_q;
  assign SE_START_O    = start_q;
  assign SE_SETUP_O    = setup_q;
  assign SE_SEED_O     = seed_q;
  assign INT_O         = int_o_q;
  // Only the wide build brings out the second test reset
  assign TRST_SECOND_O = WIDE & setup_q[scmh_pkg::SETUP_TRST2_BIT];

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_reg_wr_ack: assert property ((st_q == scmh_pkg::ST_IDLE) && acc_go && !RW_I
    && rg == scmh_pkg::RG_NONE |=> !ACK_N_O)
    else $error("register write not acknowledged one clock after edge");
  a_index_load: assert property ((st_q == scmh_pkg::ST_IDLE) && acc_go && !RW_I
    && ADDR_I == scmh_pkg::ADR_INDEX |=> ptr_q[0] == ptr_q[3] && ptr_q[1] == ptr_q[2]
    && ptr_q[0] == ptr_q[1])
    else $error("offset write did not load all four pointers");
  a_ptr_step: assert property (mem_we |=> ptr_q[$past(rg)] == $past(cur_ptr) + 11'h001)
    else $error("pointer did not advance after long word write");
  a_addr_sum: assert property (mem_we |-> mem_addr == scmh_pkg::scmh_base(rg) + cur_ptr)
    else $error("buffer address is not base plus pointer");
  a_vec_upper: assert property (mem_we && rg == scmh_pkg::RG_VEC |-> mem_wdata[31:16] == 16'h0000)
    else $error("vector upper bytes not ignored");
  a_int_clear: assert property (int_rd && SE_EVT_I == '0 |=> int_q == '0)
    else $error("status read did not clear interrupt bits");
  a_int_keep: assert property (int_rd && SE_EVT_I != '0 |=> (int_q & $past(SE_EVT_I)) != '0)
    else $error("event coincident with status read was lost");
  a_trst_narrow: assert property (!WIDE |-> !TRST_SECOND_O)
    else $error("second test reset driven in narrow build");
  a_edge_pulse: assert property (stb_fall |=> !stb_fall)
    else $error("strobe edge pulse longer than one clock");
  a_mem_read_ack: assert property (st_q == scmh_pkg::ST_MEM |=> !ACK_N_O && DATA_OE_O)
    else $error("buffer read not answered after fetch");

  c_reg_write: cover property (acc_go && !RW_I && ADDR_I == scmh_pkg::ADR_START);
  c_mem_read:  cover property (st_q == scmh_pkg::ST_MEM ##1 !ACK_N_O);
  c_int_clash: cover property (int_rd && SE_EVT_I != '0);
  c_long_wr:   cover property (mem_we && !WIDE);

endmodule

// ===== tb/scmh_host_model.sv
/*
  Host processor model for the scan master host port: one bus access
  per call, driven at the falling clock edge.
  Assumes one caller at a time and a 16 or 32 bit data path.
*/
`timescale 1ns/1ps
module scmh_host_model #(
  parameter int DATA_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              ack_n_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic                   ce_n_o,
  output logic                   stb_n_o,
  output logic                   rw_o,
  output scmh_pkg::scmh_hadr_t   addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    ce_n_o = 1'b1;
    stb_n_o = 1'b1;
    rw_o = 1'b1;
    addr_o = 5'h00;
    wdata_o = '0;
  end

  // Hold request until acknowledge, then release and wait for ack rise
  // Halves of a pair come from two calls in a row
  task automatic xfer(input logic rw, input scmh_pkg::scmh_hadr_t a,
                      input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                      output int cyc);
    int n;
    @(negedge clk_i);
    ce_n_o = 1'b0;
    stb_n_o = 1'b0;
    rw_o = rw;
    addr_o = a;
    wdata_o = rw ? ~wdata_o : wd;  // Inverted on reads, so never a stale match
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack_n_i !== 1'b0 && n < 20);
    rd = rdata_i;
    cyc = n - 1;  // Edges after the first edge that saw the strobe low
    @(negedge clk_i);
    ce_n_o = 1'b1;
    stb_n_o = 1'b1;
    rw_o = 1'b1;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack_n_i !== 1'b1 && n < 20);
  endtask
endmodule

// ===== tb/test_scan_master_host_buffer_port.sv
/*
  Self-checking bench for the scan master host port, 16 bit async build.
  Assumes the host model owns the bus and the bench plays the scan engine.
*/
`timescale 1ns/1ps
module test_scan_master_host_buffer_port;
  logic                   mclk, rst_n, ce_n, stb_n, rw, ack_n, oe, ctl_stb;
  logic                   int_o, trst2, res_stb;
  logic [15:0]            din, dout, start_o, setup_o, stat_in, rd;
  logic [31:0]            se_rdata, seed_o, res_in, d;
  logic [7:0]             evt;
  scmh_pkg::scmh_hadr_t   adr;
  scmh_pkg::scmh_se_req_t se_req;
  int                     fails, checks_done, cycles, ctl_cnt, cyc;

  scmh_host_port #(.DATA_W(16), .ASYNC_HOST(1'b1), .NUM_EVT(8)) i_scmh_host_port (
    .MCLK_I(mclk), .RESET_N_I(rst_n), .CE_N_I(ce_n), .STB_N_I(stb_n), .RW_I(rw),
    .ADDR_I(adr), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(oe), .ACK_N_O(ack_n),
    .SE_REQ_I(se_req), .SE_RDATA_O(se_rdata), .SE_EVT_I(evt), .SE_STATUS_I(stat_in),
    .SE_RESULT_I(res_in), .SE_RESULT_STB_I(res_stb), .SE_CTL_STB_O(ctl_stb),
    .SE_START_O(start_o), .SE_SETUP_O(setup_o), .SE_SEED_O(seed_o), .INT_O(int_o),
    .TRST_SECOND_O(trst2));

  scmh_host_model #(.DATA_W(16)) i_scmh_host_model (
    .clk_i(mclk), .ack_n_i(ack_n), .rdata_i(dout), .ce_n_o(ce_n), .stb_n_o(stb_n),
    .rw_o(rw), .addr_o(adr), .wdata_o(din));

  // 50 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Hang guard, and a count of control strobes to the scan engine
  always @(posedge mclk) begin
    cycles++;
    if (ctl_stb === 1'b1) ctl_cnt++;
    if (cycles == 20000) begin
      fails++;
      $display("[ERR] run_time expected below 20000 seen %0d", cycles);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A silent handshake timeout in the model would otherwise go unnoticed
  task automatic wr(input scmh_pkg::scmh_hadr_t a, input logic [15:0] v);
    i_scmh_host_model.xfer(1'b0, a, v, rd, cyc);
    chk("wr_ack_seen", 32'h1, {31'h0, cyc < 19});
  endtask

  task automatic rdc(input scmh_pkg::scmh_hadr_t a, input logic [15:0] exp, input string w);
    i_scmh_host_model.xfer(1'b1, a, 16'h0000, rd, cyc);
    chk("rd_ack_seen", 32'h1, {31'h0, cyc < 19});
    chk(w, {16'h0000, exp}, {16'h0000, rd});
  endtask

  // Scan engine side of the buffer: read data lands one edge later
  task automatic se_rd(input logic [10:0] a, output logic [31:0] q);
    @(negedge mclk);
    se_req = '{we: 1'b0, addr: a, wdata: 32'h0000_0000};
    @(posedge mclk);
    #1 q = se_rdata;
  endtask

  task automatic se_wr(input logic [10:0] a, input logic [31:0] v);
    @(negedge mclk);
    se_req = '{we: 1'b1, addr: a, wdata: v};
    @(negedge mclk);
    se_req.we = 1'b0;
  endtask

  task automatic t_reg_write();
    int c0;
    c0 = ctl_cnt;
    wr(scmh_pkg::ADR_START, 16'h1234);
    chk("wr_ack_cycles", 32'h1, {31'h0, cyc inside {2, 3}});
    chk("start", 32'h1234, {16'h0, start_o});
    wr(scmh_pkg::ADR_SETUP, 16'h0002);
    chk("setup", 32'h0002, {16'h0, setup_o});
    chk("trst_second", 32'h0, {31'h0, trst2});
    chk("ctl_pulses", 32'd2, ctl_cnt - c0);
  endtask

  // One offset write must place all four pointers; capture region skipped
  task automatic t_regions();
    logic [15:0] ms, ls;
    wr(scmh_pkg::ADR_INDEX, 16'h0005);
    for (int r = 0; r < 4; r++) begin
      if (r == 1) continue;  // Capture region is not written by the host here; the port itself accepts host writes to it
      for (int k = 0; k < 2; k++) begin
        ms = 16'(16'hA100 + r * 16 + k);
        ls = 16'(16'hC300 + r * 16 + k);
        wr(scmh_pkg::ADR_REGION0 + 5'(r), ms);
        wr(scmh_pkg::ADR_REGION0 + 5'(r), ls);
        se_rd(11'(r * 256 + 5 + k), d);
        chk("region_word", {ms, ls}, d);
      end
    end
  endtask

  task automatic t_capture();
    se_wr(11'h105, 32'h1122_3344);
    se_wr(11'h106, 32'h5566_7788);
    rdc(scmh_pkg::ADR_REGION0 + 5'h01, 16'h1122, "cap0_ms");
    rdc(scmh_pkg::ADR_REGION0 + 5'h01, 16'h3344, "cap0_ls");
    rdc(scmh_pkg::ADR_REGION0 + 5'h01, 16'h5566, "cap1_ms");
    rdc(scmh_pkg::ADR_REGION0 + 5'h01, 16'h7788, "cap1_ls");
  endtask

  task automatic t_vector();
    wr(scmh_pkg::ADR_PTR4, 16'h0003);
    wr(scmh_pkg::ADR_REGION0 + 5'h04, 16'hFFFF);
    wr(scmh_pkg::ADR_REGION0 + 5'h04, 16'h5678);
    se_rd(11'h403, d);
    chk("vector_word", 32'h0000_5678, d);
    rdc(scmh_pkg::ADR_PTR4, 16'h0004, "vector_ptr");
    // Entry with a non-idle usage code always carries a nonzero count
    wr(scmh_pkg::ADR_PTR4 + 5'h01, 16'h0002);
    wr(scmh_pkg::ADR_REGION0 + 5'h05, 16'h0001);
    wr(scmh_pkg::ADR_REGION0 + 5'h05, 16'h0002);
    se_rd(11'h502, d);
    chk("hdr_trl_word", 32'h0001_0002, d);
    rdc(scmh_pkg::ADR_PTR4 + 5'h01, 16'h0003, "hdr_trl_ptr");
  endtask

  task automatic t_pairs();
    wr(scmh_pkg::ADR_SEED, 16'h1111);
    wr(scmh_pkg::ADR_SEED, 16'h2222);
    chk("seed", 32'h2222_1111, seed_o);
    @(negedge mclk);
    res_in = 32'h8765_4321;
    res_stb = 1'b1;
    @(negedge mclk);
    res_stb = 1'b0;
    res_in = 32'h0F0F_0F0F;  // Later value must not leak into the result
    rdc(scmh_pkg::ADR_RESULT, 16'h4321, "result_ls");
    rdc(scmh_pkg::ADR_RESULT, 16'h8765, "result_ms");
  endtask

  // Enabled event raises the line; masked one only sets status
  task automatic t_irq();
    wr(scmh_pkg::ADR_INTMASK, 16'h0001);
    @(negedge mclk);
    evt = 8'h01;
    @(negedge mclk);
    evt = 8'h00;
    repeat (2) @(negedge mclk);
    chk("int_raised", 32'h1, {31'h0, int_o});
    rdc(scmh_pkg::ADR_INTSTAT, 16'h0001, "int_status");
    repeat (2) @(negedge mclk);
    chk("int_cleared", 32'h0, {31'h0, int_o});
    evt = 8'h02;
    @(negedge mclk);
    evt = 8'h00;
    repeat (2) @(negedge mclk);
    chk("int_masked", 32'h0, {31'h0, int_o});
    rdc(scmh_pkg::ADR_INTSTAT, 16'h0002, "int_status_masked");
    rdc(scmh_pkg::ADR_INTSTAT, 16'h0000, "int_status_empty");
    // Event lands in the cycle the status read is taken: read misses it,
    // but the clear must not swallow it
    fork
      rdc(scmh_pkg::ADR_INTSTAT, 16'h0000, "int_status_clash");
      begin
        repeat (3) @(negedge mclk);
        evt = 8'h04;
        @(negedge mclk);
        evt = 8'h00;
      end
    join
    rdc(scmh_pkg::ADR_INTSTAT, 16'h0004, "int_status_kept");
  endtask

  task automatic t_status();
    @(negedge mclk);
    stat_in = 16'hBEEF;
    rdc(scmh_pkg::ADR_STATUS, 16'hBEEF, "status");
    wr(5'h1F, 16'hFFFF);
    rdc(5'h1F, 16'h0000, "unmapped");
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    ctl_cnt = 0;
    rst_n = 1'b0;
    evt = 8'h00;
    stat_in = 16'h0000;
    res_in = 32'h0000_0000;
    res_stb = 1'b0;
    se_req = '{we: 1'b0, addr: 11'h000, wdata: 32'h0000_0000};
    repeat (8) @(negedge mclk);
    chk("ack_reset", 32'h1, {31'h0, ack_n});
    chk("oe_reset", 32'h0, {31'h0, oe});
    rst_n = 1'b1;
    t_reg_write();
    t_regions();
    t_capture();
    t_vector();
    t_pairs();
    t_irq();
    t_status();
    end_sim();
  end
endmodule
